/* File: vic_pkg.sv */
package vic_pkg;

    // =====================================================================
    // Sizes
    localparam int unsigned NSRC      = 5;
    localparam int unsigned PC_W      = 11;
    localparam int unsigned STK_DEPTH = 6;
    localparam int unsigned LVL_W     = 3;

    // =====================================================================
    // Source indices, lowest index has the highest priority
    localparam int unsigned SRC_PIN    = 0;
    localparam int unsigned SRC_TIMER0 = 1;
    localparam int unsigned SRC_TIMER1 = 2;
    localparam int unsigned SRC_CONV   = 3;
    localparam int unsigned SRC_NVW    = 4;

    // =====================================================================
    // Vector addresses
    localparam logic [PC_W-1:0] VEC_PIN    = 11'h004;
    localparam logic [PC_W-1:0] VEC_TIMER0 = 11'h008;
    localparam logic [PC_W-1:0] VEC_TIMER1 = 11'h00C;
    localparam logic [PC_W-1:0] VEC_CONV   = 11'h010;
    localparam logic [PC_W-1:0] VEC_NVW    = 11'h014;

    // =====================================================================
    // Pin edge select codes
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // =====================================================================
    // Reset values, level step and full level
    localparam logic [PC_W-1:0] PC_RST  = 11'h000;
    localparam logic [LVL_W-1:0] LVL_RST = 3'h0;
    localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
    localparam logic [LVL_W-1:0] LVL_MAX = 3'h6;

    function automatic logic [PC_W-1:0] vic_vector(input logic [2:0] idx);
        unique case (idx)
            3'h0:    vic_vector = VEC_PIN;
            3'h1:    vic_vector = VEC_TIMER0;
            3'h2:    vic_vector = VEC_TIMER1;
            3'h3:    vic_vector = VEC_CONV;
            default: vic_vector = VEC_NVW;
        endcase
    endfunction : vic_vector

endpackage : vic_pkg

/* File: vic_stk_if.sv */
`timescale 1ns/1ps
interface vic_stk_if;
    logic                           push;
    logic                           pop;
    logic [vic_pkg::PC_W-1:0]       push_addr;
    logic [vic_pkg::PC_W-1:0]       top_addr;
    logic                           full;
    logic [vic_pkg::LVL_W-1:0]      level;

    modport stack (input push, input pop, input push_addr, output top_addr, output full, output level);
    modport user  (output push, output pop, output push_addr, input top_addr, input full, input level);
endinterface : vic_stk_if

/* File: vic_edge_det.sv */
`timescale 1ns/1ps
module vic_edge_det (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] edge_sel_i,
    output logic            edge_o
);
    logic pin_q;
    logic rise;
    logic fall;

    // =====================================================================
    // Previous pin level, tracked in reset too so no false edge follows it
    always_ff @(posedge clk_i) begin
        pin_q <= pin_i;
    end

    assign rise = pin_i & ~pin_q;
    assign fall = ~pin_i & pin_q;

    always_comb begin
        unique case (edge_sel_i)
            vic_pkg::EDGE_NONE:    edge_o = 1'b0;
            vic_pkg::EDGE_RISING:  edge_o = rise;
            vic_pkg::EDGE_FALLING: edge_o = fall;
            vic_pkg::EDGE_BOTH:    edge_o = rise | fall;
        endcase
    end

    a_edge_select: assert property (@(posedge clk_i) disable iff (srst_i)
        (edge_sel_i == vic_pkg::EDGE_FALLING && $fell(pin_i)) |-> edge_o)
        else $error("falling edge not detected");
endmodule : vic_edge_det

/* File: vic_stack.sv */
`timescale 1ns/1ps
module vic_stack (
    input  wire logic  clk_i,
    input  wire logic  srst_i,
    vic_stk_if.stack   stk
);
    logic [vic_pkg::PC_W-1:0]  mem_q [vic_pkg::STK_DEPTH];
    logic [vic_pkg::LVL_W-1:0] lvl_q;

    assign stk.full     = (lvl_q == vic_pkg::LVL_MAX);
    assign stk.level    = lvl_q;
    assign stk.top_addr = (lvl_q == vic_pkg::LVL_RST) ? vic_pkg::PC_RST : mem_q[lvl_q - vic_pkg::LVL_ONE];

    // =====================================================================
    // Level pointer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lvl_q <= vic_pkg::LVL_RST;
        end else if (stk.push && !stk.full) begin
            lvl_q <= lvl_q + vic_pkg::LVL_ONE;
        end else if (stk.pop && lvl_q != vic_pkg::LVL_RST) begin
            lvl_q <= lvl_q - vic_pkg::LVL_ONE;
        end
    end

    // =====================================================================
    // Storage, one slot per level
    genvar g;
    generate
        for (g = 0; g < vic_pkg::STK_DEPTH; g++) begin : g_slot
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    mem_q[g] <= vic_pkg::PC_RST;
                end else if (stk.push && !stk.full && lvl_q == vic_pkg::LVL_W'(g)) begin
                    mem_q[g] <= stk.push_addr;
                end
            end
        end
    endgenerate

    a_push_pop: assert property (@(posedge clk_i) disable iff (srst_i)
        (stk.push && !stk.full && !stk.pop) ##1 (stk.pop && !stk.push)
        |-> stk.top_addr == $past(stk.push_addr))
        else $error("popped address differs from pushed one");
endmodule : vic_stack

/* File: vic_top.sv */
`timescale 1ns/1ps
// Operation
// - On a taken request push the next address and load the source vector.
// - Vectors: pin 04H, timer0 08H, timer1 0CH, converter 10H, write 14H.
// - Simultaneous requests served pin, timer0, timer1, converter, write.
// - Requests are sampled and served at the instruction phase pulse.
// - Entering service clears the global enable, blocking nesting.
// - Requests during blocked service still set and keep their flags.
// - A full stack holds off any request until the pointer drops.
// - Return from interrupt pops the saved address into the counter.
// - Enable bits and flags kept; cleared global enable blocks all service.
// - Hardware sets a flag on its event; service needs its enable bit.
// - Sources: timers, converter done, nonvolatile write done, external pin.
// - Service clears the served flag together with the global enable.
// - A set flag stays until served or cleared by software.
// - Edge select picks falling, rising or both pin edges.
// - Only the program counter is saved on entry.
module vic_top (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       instruction_phase_pulse_i,
    input  wire logic                       ext_pin_i,
    input  wire logic                       pin_edge_select_lo_i,
    input  wire logic                       pin_edge_select_hi_i,
    input  wire logic                       timer0_ovf_i,
    input  wire logic                       timer1_ovf_i,
    input  wire logic                       conv_done_i,
    input  wire logic                       nv_write_done_i,
    input  wire logic                       pin_irq_enable_i,
    input  wire logic                       timer0_irq_enable_i,
    input  wire logic                       timer1_irq_enable_i,
    input  wire logic                       conv_done_irq_enable_i,
    input  wire logic                       nv_write_irq_enable_i,
    input  wire logic                       global_irq_enable_set_i,
    input  wire logic                       global_irq_enable_clr_i,
    input  wire logic [vic_pkg::NSRC-1:0]   flag_clr_i,
    input  wire logic [vic_pkg::PC_W-1:0]   next_pc_i,
    input  wire logic                       call_i,
    input  wire logic                       ret_i,
    input  wire logic                       reti_i,
    output logic                            global_irq_enable_o,
    output logic                            pin_irq_flag_o,
    output logic                            timer0_irq_flag_o,
    output logic                            timer1_irq_flag_o,
    output logic                            conv_done_irq_flag_o,
    output logic                            nv_write_irq_flag_o,
    output logic                            pc_load_o,
    output logic [vic_pkg::PC_W-1:0]        pc_value_o,
    output logic                            irq_taken_o,
    output logic                            stack_full_o,
    output logic [vic_pkg::LVL_W-1:0]       stack_level_o
);

    // =====================================================================
    // Declarations
    vic_stk_if stk ();

    logic [vic_pkg::NSRC-1:0] flag_q;
    logic [vic_pkg::NSRC-1:0] flag_d;
    logic [vic_pkg::NSRC-1:0] event_set;
    logic [vic_pkg::NSRC-1:0] enable;
    logic [vic_pkg::NSRC-1:0] pending;
    logic [vic_pkg::NSRC-1:0] take_clr;
    logic                     gie_q;
    logic                     pin_edge;
    logic                     take;
    logic                     do_return;
    logic [2:0]               win_idx;
    logic                     pc_load_q;
    logic [vic_pkg::PC_W-1:0] pc_value_q;
    logic                     taken_q;

    // Highest priority pending source, lowest index wins
    function automatic logic [2:0] vic_pick(input logic [vic_pkg::NSRC-1:0] req);
        vic_pick = 3'h0;
        for (int i = vic_pkg::NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                vic_pick = i[2:0];
            end
        end
    endfunction : vic_pick

    // =====================================================================
    // Request sources
    vic_edge_det u_edge (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .pin_i      (ext_pin_i),
        .edge_sel_i ({pin_edge_select_hi_i, pin_edge_select_lo_i}),
        .edge_o     (pin_edge)
    );

    assign event_set[vic_pkg::SRC_PIN]    = pin_edge;
    assign event_set[vic_pkg::SRC_TIMER0] = timer0_ovf_i;
    assign event_set[vic_pkg::SRC_TIMER1] = timer1_ovf_i;
    assign event_set[vic_pkg::SRC_CONV]   = conv_done_i;
    assign event_set[vic_pkg::SRC_NVW]    = nv_write_done_i;

    assign enable[vic_pkg::SRC_PIN]    = pin_irq_enable_i;
    assign enable[vic_pkg::SRC_TIMER0] = timer0_irq_enable_i;
    assign enable[vic_pkg::SRC_TIMER1] = timer1_irq_enable_i;
    assign enable[vic_pkg::SRC_CONV]   = conv_done_irq_enable_i;
    assign enable[vic_pkg::SRC_NVW]    = nv_write_irq_enable_i;

    // =====================================================================
    // Arbitration
    // enable gates service
    assign pending = flag_q & enable;
    assign win_idx = vic_pick(pending);
    assign take = instruction_phase_pulse_i & gie_q & (|pending) & ~stk.full & ~call_i;
    assign do_return = ret_i | reti_i;

    assign take_clr = take ? (vic_pkg::NSRC'(1) << win_idx) : '0;

    // =====================================================================
    // Request flags
    // set wins over clear
    assign flag_d = (flag_q & ~flag_clr_i & ~take_clr) | event_set;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // =====================================================================
    // Global enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gie_q <= 1'b0;
        end else if (take) begin
            gie_q <= 1'b0;
        end else if (global_irq_enable_set_i) begin
            gie_q <= 1'b1;
        end else if (global_irq_enable_clr_i) begin
            gie_q <= 1'b0;
        end
    end

    // =====================================================================
    // Return address stack
    // only the counter is pushed
    assign stk.push      = take | call_i;
    assign stk.push_addr = next_pc_i;
    assign stk.pop       = do_return & ~stk.push;

    vic_stack u_stack (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .stk    (stk)
    );

    // =====================================================================
    // Program counter load
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pc_load_q  <= 1'b0;
            pc_value_q <= vic_pkg::PC_RST;
            taken_q    <= 1'b0;
        end else begin
            pc_load_q <= take | stk.pop;
            taken_q   <= take;
            if (take) begin
                pc_value_q <= vic_pkg::vic_vector(win_idx);
            end else if (stk.pop) begin
                pc_value_q <= stk.top_addr;
            end
        end
    end

    // =====================================================================
    // Outputs
    assign global_irq_enable_o  = gie_q;
    assign pin_irq_flag_o       = flag_q[vic_pkg::SRC_PIN];
    assign timer0_irq_flag_o    = flag_q[vic_pkg::SRC_TIMER0];
    assign timer1_irq_flag_o    = flag_q[vic_pkg::SRC_TIMER1];
    assign conv_done_irq_flag_o = flag_q[vic_pkg::SRC_CONV];
    assign nv_write_irq_flag_o  = flag_q[vic_pkg::SRC_NVW];
    assign pc_load_o            = pc_load_q;
    assign pc_value_o           = pc_value_q;
    assign irq_taken_o          = taken_q;
    assign stack_full_o         = stk.full;
    assign stack_level_o        = stk.level;

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_entry;
        irq_taken_o && pc_load_o;
    endsequence

    sequence s_blocked;
        !global_irq_enable_o && !irq_taken_o;
    endsequence

    a_vector_jump: assert property (take ##1 s_entry |->
        pc_value_o == vic_pkg::vic_vector($past(win_idx)))
        else $error("wrong vector loaded");

    a_push_next: assert property (take |=> stack_level_o == $past(stack_level_o) + vic_pkg::LVL_ONE)
        else $error("entry did not push");

    a_gie_cleared: assert property (take |=> s_blocked or (!global_irq_enable_o ##0 1'b1))
        else $error("global enable kept on entry");

    a_flag_cleared: assert property (take |=>
        !(flag_q[$past(win_idx)]) || $past(event_set[win_idx]))
        else $error("served flag not cleared");

    a_priority_pin: assert property (take && pending[vic_pkg::SRC_PIN] |->
        win_idx == 3'(vic_pkg::SRC_PIN))
        else $error("pin source not first");

    a_phase_only: assert property (irq_taken_o |-> $past(instruction_phase_pulse_i))
        else $error("service outside phase pulse");

    a_full_blocks: assert property (stack_full_o |=> !irq_taken_o)
        else $error("service with full stack");

    a_gie_blocks: assert property (!global_irq_enable_o |=> !irq_taken_o)
        else $error("service with global enable off");

    a_gie_sw_clear: assert property (global_irq_enable_clr_i && !global_irq_enable_set_i
        |=> !global_irq_enable_o)
        else $error("software clear of global enable ignored");

    a_flag_sticky: assert property (flag_q[vic_pkg::SRC_TIMER0] && !flag_clr_i[vic_pkg::SRC_TIMER0] && !take
        |=> flag_q[vic_pkg::SRC_TIMER0])
        else $error("flag dropped without service");

    a_event_kept: assert property (event_set[vic_pkg::SRC_CONV] && !gie_q
        |=> conv_done_irq_flag_o)
        else $error("event lost while blocked");

    a_one_at_time: assert property (take |=> !take)
        else $error("two entries back to back");

    a_reti_load: assert property (reti_i && !stk.push && stack_level_o != vic_pkg::LVL_RST
        |=> pc_load_o && pc_value_o == $past(stk.top_addr))
        else $error("return address not loaded");

endmodule : vic_top

/* File: vic_core_model.sv */
`timescale 1ns/1ps
// =====================================================================
// Program sequencer seen by the interrupt logic
module vic_core_model #(
    parameter int unsigned PHASE_DIV = 4
) (
    input  wire logic                     clk_i,
    input  wire logic                     srst_i,
    input  wire logic                     pc_load_i,
    input  wire logic [vic_pkg::PC_W-1:0] pc_value_i,
    output logic                          phase_o,
    output logic [vic_pkg::PC_W-1:0]      next_pc_o
);
    logic [7:0]                cnt_q;
    logic [vic_pkg::PC_W-1:0]  pc_q;

    always_ff @(posedge clk_i) begin
        if (srst_i || cnt_q == 8'(PHASE_DIV - 1)) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign phase_o = (cnt_q == 8'(PHASE_DIV - 1)) && !srst_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pc_q <= vic_pkg::PC_RST;
        end else if (pc_load_i) begin
            pc_q <= pc_value_i;
        end else if (phase_o) begin
            pc_q <= pc_q + 11'h001;
        end
    end

    assign next_pc_o = pc_q + 11'h001;
endmodule : vic_core_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        ext_pin = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [3:0]  evt = 4'h0;
    logic [4:0]  en = 5'h00;
    logic [9:0]  ctl = 10'h000;
    logic        phase, gie, pc_load, taken, full;
    logic [4:0]  flags;
    logic [2:0]  level;
    logic [10:0] next_pc, pc_value, push_addr_q, call_addr;
    logic [31:0] st;
    int          mismatches = 0;
    int          total_checks = 0;
    int          takes = 0;

    always #5 clk_i = ~clk_i;

    vic_core_model #(.PHASE_DIV(4)) core (.clk_i(clk_i), .srst_i(srst_i), .pc_load_i(pc_load),
        .pc_value_i(pc_value), .phase_o(phase), .next_pc_o(next_pc));

    vic_top uut (.clk_i(clk_i), .srst_i(srst_i), .instruction_phase_pulse_i(phase), .ext_pin_i(ext_pin),
        .pin_edge_select_lo_i(sel[0]), .pin_edge_select_hi_i(sel[1]), .timer0_ovf_i(evt[0]),
        .timer1_ovf_i(evt[1]), .conv_done_i(evt[2]), .nv_write_done_i(evt[3]), .pin_irq_enable_i(en[0]),
        .timer0_irq_enable_i(en[1]), .timer1_irq_enable_i(en[2]), .conv_done_irq_enable_i(en[3]),
        .nv_write_irq_enable_i(en[4]), .global_irq_enable_set_i(ctl[9]), .global_irq_enable_clr_i(ctl[8]),
        .flag_clr_i(ctl[7:3]), .next_pc_i(next_pc), .call_i(ctl[2]), .ret_i(ctl[1]), .reti_i(ctl[0]),
        .global_irq_enable_o(gie), .pin_irq_flag_o(flags[0]), .timer0_irq_flag_o(flags[1]),
        .timer1_irq_flag_o(flags[2]), .conv_done_irq_flag_o(flags[3]), .nv_write_irq_flag_o(flags[4]),
        .pc_load_o(pc_load), .pc_value_o(pc_value), .irq_taken_o(taken), .stack_full_o(full),
        .stack_level_o(level));

    // Address the design would push at this edge, and entry count
    always @(posedge clk_i) begin
        push_addr_q <= next_pc;
        if (taken === 1'b1) takes++;
    end

    // =====================================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [10:0] exp_vec(input int k);
        return 11'(4 * (k + 1));
    endfunction : exp_vec

    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_vec(input string name, input logic [10:0] exp, input logic [10:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_vec

    // Control pulse: gie set, gie clr, flag clr[5], call, ret, reti
    task automatic pulse_ctl(input logic [9:0] v);
        @(posedge clk_i) ctl <= v;
        @(posedge clk_i) ctl <= 10'h000;
    endtask : pulse_ctl

    task automatic pulse_evt(input logic [3:0] m);
        @(posedge clk_i) evt <= m;
        @(posedge clk_i) evt <= 4'h0;
    endtask : pulse_evt

    task automatic no_take(input int cyc);
        int t0;
        t0 = takes;
        repeat (cyc) @(posedge clk_i);
        #1;
        chk_vec("entries", 11'(t0), 11'(takes));
    endtask : no_take

    task automatic wait_take(input int idx);
        int          n;
        logic [10:0] ret_exp;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (taken !== 1'b1 && n < 40);
        chk_bit("irq_taken_o", 1'b1, taken);
        chk_bit("pc_load_o", 1'b1, pc_load);
        chk_vec("pc_value_o", exp_vec(idx), pc_value);
        chk_bit("global_irq_enable_o", 1'b0, gie);
        chk_bit("served flag", 1'b0, flags[idx]);
        ret_exp = push_addr_q;
        pulse_ctl(10'h001);
        #1;
        chk_bit("pc_load_o", 1'b1, pc_load);
        chk_vec("return address", ret_exp, pc_value);
    endtask : wait_take

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // =====================================================================
    // Scenarios
    initial begin
        st = 32'h0000_f1ab;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_bit("global_irq_enable_o", 1'b0, gie);
        chk_vec("flags", 11'h000, 11'(flags));
        chk_vec("stack_level_o", 11'h000, 11'(level));
        chk_vec("pc_value_o", 11'h000, pc_value);
        @(posedge clk_i) begin
            sel <= vic_pkg::EDGE_RISING;
            en  <= 5'h1f;
        end
        @(posedge clk_i) begin
            ext_pin <= 1'b1;
            evt     <= 4'hf;
        end
        @(posedge clk_i) evt <= 4'h0;
        repeat (3) @(posedge clk_i);
        #1;
        chk_vec("flags", 11'h01f, 11'(flags));
        no_take(12);
        for (int k = 0; k < 5; k++) begin
            pulse_ctl(10'h200);
            wait_take(k);
            chk_vec("pending flags", 11'(5'h1f & ~((5'h01 << (k + 1)) - 5'h01)), 11'(flags));
        end
        @(posedge clk_i) begin
            sel     <= vic_pkg::EDGE_NONE;
            ext_pin <= 1'b0;
        end
        pulse_ctl(10'h008);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i) sel <= 2'(c);
            @(posedge clk_i) ext_pin <= 1'b1;
            repeat (3) @(posedge clk_i);
            #1;
            chk_bit("rising pin flag", (c == 1 || c == 3), flags[0]);
            pulse_ctl(10'h008);
            @(posedge clk_i) ext_pin <= 1'b0;
            repeat (3) @(posedge clk_i);
            #1;
            chk_bit("falling pin flag", (c == 2 || c == 3), flags[0]);
            pulse_ctl(10'h008);
        end
        @(posedge clk_i) en <= 5'h1d;
        pulse_evt(4'h1);
        pulse_ctl(10'h200);
        no_take(12);
        chk_bit("timer0 flag", 1'b1, flags[1]);
        chk_bit("global_irq_enable_o", 1'b1, gie);
        pulse_ctl(10'h100);
        #1;
        chk_bit("global_irq_enable_o", 1'b0, gie);
        @(posedge clk_i) en <= 5'h1f;
        no_take(8);
        pulse_ctl(10'h200);
        wait_take(1);
        for (int i = 0; i < 16; i++) begin
            st = lfsr_next(st);
            pulse_evt(st[3:0]);
            repeat (2) @(posedge clk_i);
            #1;
            chk_vec("random flags", 11'({st[3:0], 1'b0}), 11'(flags));
            pulse_ctl(10'h0f0);
        end
        @(posedge clk_i) ctl <= 10'h004;
        @(posedge clk_i) ctl <= 10'h002;
        #1 call_addr = push_addr_q;
        @(posedge clk_i) ctl <= 10'h000;
        #1;
        chk_bit("pc_load_o", 1'b1, pc_load);
        chk_vec("return address", call_addr, pc_value);
        chk_vec("stack_level_o", 11'h000, 11'(level));
        repeat (6) pulse_ctl(10'h004);
        #1;
        chk_bit("stack_full_o", 1'b1, full);
        chk_vec("stack_level_o", 11'h006, 11'(level));
        pulse_evt(4'h2);
        pulse_ctl(10'h200);
        no_take(12);
        chk_bit("timer1 flag", 1'b1, flags[2]);
        pulse_ctl(10'h002);
        #1;
        chk_vec("stack_level_o", 11'h005, 11'(level));
        wait_take(2);
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
endmodule : testbench
